/* File: pswc_consts.svh */
// constants for the power save and wake control block
`ifndef PSWC_CONSTS_SVH
`define PSWC_CONSTS_SVH

// ----------------------------------------------------------------
// reset control register field positions
// ----------------------------------------------------------------
`define PSWC_RCR_SLEEP_BIT      3
`define PSWC_RCR_IDLE_BIT       2
`define PSWC_RCR_WDT_TIMEOUT_FLAG_BIT       4
`define PSWC_RCR_SOFT_EN_BIT    5
`define PSWC_RCR_LVL_LSB        8
`define PSWC_RCR_LVL_MSB        11
`define PSWC_RCR_LOWVOLT_DETECT_ENABLE_BIT      12
`define PSWC_RCR_BANDGAP_STABLE_FLAG_BIT       13
`define PSWC_RCR_RESET          16'h0000
// ----------------------------------------------------------------
// configuration word offsets and fields
// ----------------------------------------------------------------
`define PSWC_CFG_OSC_ADDR       24'hF80000
`define PSWC_CFG_WDT_ADDR       24'hF80002
`define PSWC_CFG_BORPOR_ADDR    24'hF80004
`define PSWC_CFG_BOOT_ADDR      24'hF80006
`define PSWC_CFG_SECURE_ADDR    24'hF80008
`define PSWC_CFG_GENERAL_ADDR   24'hF8000A
`define PSWC_CFG_DEBUG_ADDR     24'hF8000C
`define PSWC_CFG_WDT_FUSE_BIT   15
`define PSWC_CFG_ERASED         16'hFFFF
// ----------------------------------------------------------------
// wake timing
// ----------------------------------------------------------------
`define PSWC_CLK_MHZ            40
`define PSWC_POWERON_DELAY_NS            10000
`define PSWC_POWERON_DELAY_CYC           ((`PSWC_POWERON_DELAY_NS * `PSWC_CLK_MHZ + 999) / 1000)
`define PSWC_POWERUP_TIMER_DELAY_CYC          16
`define PSWC_BANDGAP_STABLE_FLAG_CYC           64

`endif

/* File: pswc_pkg.sv */
// types for the power save and wake control block
package pswc_pkg;
    typedef enum logic [2:0] {
        PSWC_OSC_FRC,
        PSWC_OSC_FRC_PLL,
        PSWC_OSC_PRIMARY,
        PSWC_OSC_LP,
        PSWC_OSC_LOW_POWER_INTERNAL_RC,
        PSWC_OSC_EC,
        PSWC_OSC_EXTERNAL_RC_OSC,
        PSWC_OSC_XT_PLL
    } pswc_osc_t;
    typedef enum logic [2:0] {
        PSWC_RUN,
        PSWC_SLEEP,
        PSWC_IDLE,
        PSWC_WAKE_DELAY,
        PSWC_WAIT_CLOCK
    } pswc_state_t;
endpackage

/* File: pswc_delay_timer.sv */
// down counter that times the wake delays
`timescale 1ns/10ps
module pswc_delay_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] count,
    output logic                  busy
);
    logic [WIDTH-1:0] remain;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end
    assign busy = (remain != '0);
endmodule // pswc_delay_timer

/* File: pswc_power_save_wake.sv */
// power save and wake control: watchdog gating, low voltage control, sleep and idle
// Summary of operation
// - erased watchdog fuse reads one, forces watchdog
// - fuse zero lets soft enable bit five
// - watchdog overflow resets device except in sleep
// - overflow during sleep wakes instead of reset
// - threshold select sits at bits eleven..eight
// - bit thirteen flags reference settled
// - detector works only with bit twelve set
// - power save operand picks sleep or idle
// - sleep gates cpu, peripherals, oscillator, monitor
// - sleep ends on interrupt, reset, watchdog
// - wake restarts clock named by current select, or by the osc config word with switching off
// - crystal wake waits startup, lock, power delays
// - rc or external clock wake waits ten microseconds
// - low power crystal kept running skips timers
// - interrupt wake vectors and sets sleep flag
// - dead clock traps to fast rc or stalls
// - non poweron reset sets sleep, poweron clears
// - watchdog wake sets sleep and timeout flags
// - idle gates only the cpu clock
// - idle wake resumes at once, next instruction
// - idle flag set by wake or non poweron reset
// - config words twenty four bits, low sixteen used
`timescale 1ns/10ps
`include "pswc_consts.svh"
module pswc_power_save_wake
    import pswc_pkg::*;
#(
    parameter int             LOCK_CYC = 4,
    parameter int             OST_CYC  = 1024
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         por_event,
    input  wire logic         bor_event,
    input  wire logic         master_clear_pin_event,
    input  wire logic         power_save_instruction_exec,
    input  wire logic         power_save_instruction_is_idle,
    input  wire logic         wdt_clear_instruction,
    input  wire logic         wdt_overflow,
    input  wire logic         irq_wake,
    input  wire logic         clock_switch_enable,
    input  wire logic [2:0]   current_osc_select,
    input  wire logic         pll_locked,
    input  wire logic         osc_running,
    input  wire logic         lp_ran_in_sleep,
    input  wire logic         clock_fail_enable,
    input  wire logic         reference_ready,
    input  wire logic         rcr_write,
    input  wire logic [15:0]  rcr_wdata,
    input  wire logic [23:0]  cfg_addr,
    input  wire logic [15:0]  osc_cfg_word,
    input  wire logic [15:0]  wdt_cfg_word,
    input  wire logic [15:0]  borpor_cfg_word,
    input  wire logic [15:0]  boot_cfg_word,
    input  wire logic [15:0]  secure_cfg_word,
    input  wire logic [15:0]  general_cfg_word,
    input  wire logic [15:0]  debug_cfg_word,
    output logic [23:0]       cfg_rdata,
    output logic [15:0]       reset_control_register,
    output logic              wdt_active,
    output logic              wdt_counter_clear,
    output logic              wdt_reset_request,
    output logic              cpu_clk_enable,
    output logic              periph_clk_enable,
    output logic              osc_enable,
    output logic              low_power_internal_rc_enable,
    output logic              clock_fail_monitor_active,
    output logic              lowvolt_detect_active,
    output logic [3:0]        lowvolt_threshold_select,
    output logic              interrupt_vector_take,
    output logic              clock_fail_trap,
    output logic [2:0]        wake_osc
);
    // ----------------------------------------------------------------
    // state and registers
    // ----------------------------------------------------------------
    pswc_state_t state;
    pswc_state_t next_state;
    logic        wake_by_irq;
    logic        load_delay;
    logic [15:0] delay_count;
    logic        delay_busy;
    logic [7:0]  bandgap_stable_flag_cnt;
    logic        bandgap_stable_flag;
    logic        any_reset;

    assign any_reset = por_event | bor_event | master_clear_pin_event;

    // ----------------------------------------------------------------
    // watchdog enable
    // ----------------------------------------------------------------
    // an erased part reads all ones, so the fuse defaults to enabled
    assign wdt_active = wdt_cfg_word[`PSWC_CFG_WDT_FUSE_BIT]
                      | reset_control_register[`PSWC_RCR_SOFT_EN_BIT];
    assign wdt_counter_clear = wdt_clear_instruction;
    assign wdt_reset_request = wdt_active & wdt_overflow & (state != PSWC_SLEEP);

    // ----------------------------------------------------------------
    // clock gating
    // ----------------------------------------------------------------
    assign cpu_clk_enable    = (state == PSWC_RUN);
    assign periph_clk_enable = (state == PSWC_RUN) | (state == PSWC_IDLE);
    assign osc_enable        = (state != PSWC_SLEEP) | lp_ran_in_sleep;
    assign clock_fail_monitor_active = clock_fail_enable & (state != PSWC_SLEEP);
    assign low_power_internal_rc_enable = (state == PSWC_SLEEP) ? wdt_active
                                               : (wdt_active | clock_fail_enable);

    // ----------------------------------------------------------------
    // low voltage detector
    // ----------------------------------------------------------------
    assign lowvolt_threshold_select =
        reset_control_register[`PSWC_RCR_LVL_MSB:`PSWC_RCR_LVL_LSB];
    assign lowvolt_detect_active = reset_control_register[`PSWC_RCR_LOWVOLT_DETECT_ENABLE_BIT];

    // reference needs a settling time after the detector is enabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bandgap_stable_flag_cnt <= 8'h00;
            bandgap_stable_flag     <= 1'b0;
        end else if (!lowvolt_detect_active) begin
            bandgap_stable_flag_cnt <= 8'h00;
            bandgap_stable_flag     <= 1'b0;
        end else if (bandgap_stable_flag_cnt == 8'(`PSWC_BANDGAP_STABLE_FLAG_CYC)) begin
            bandgap_stable_flag     <= reference_ready;
        end else begin
            bandgap_stable_flag_cnt <= bandgap_stable_flag_cnt + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // wake delay selection
    // ----------------------------------------------------------------
    logic [2:0] osc_src;
    logic       is_crystal;
    logic       lp_fast;
    assign osc_src = clock_switch_enable ? current_osc_select
                                         : osc_cfg_word[2:0];
    assign is_crystal = (osc_src == PSWC_OSC_PRIMARY) | (osc_src == PSWC_OSC_XT_PLL)
                      | (osc_src == PSWC_OSC_LP);
    assign lp_fast = (osc_src == PSWC_OSC_LP) & lp_ran_in_sleep;
    assign delay_count = (is_crystal && !lp_fast) ?
        16'(`PSWC_POWERON_DELAY_CYC + `PSWC_POWERUP_TIMER_DELAY_CYC + LOCK_CYC + OST_CYC) :
        16'(`PSWC_POWERON_DELAY_CYC);
    assign load_delay = (state == PSWC_SLEEP) && (next_state == PSWC_WAKE_DELAY);

    pswc_delay_timer #(
        .WIDTH (16)
    ) u_delay (
        .clk   (clk),
        .rst_n (rst_n),
        .load  (load_delay),
        .count (delay_count),
        .busy  (delay_busy)
    );

    // ----------------------------------------------------------------
    // power state machine
    // ----------------------------------------------------------------
    logic wake_src;
    logic clock_ok;
    assign wake_src = irq_wake | any_reset | (wdt_active & wdt_overflow);
    assign clock_ok = osc_running & ((osc_src != PSWC_OSC_XT_PLL
                    && osc_src != PSWC_OSC_FRC_PLL) || pll_locked);

    always_comb begin
        next_state = state;
        case (state)
            PSWC_RUN: begin
                if (power_save_instruction_exec) begin
                    next_state = power_save_instruction_is_idle ? PSWC_IDLE : PSWC_SLEEP;
                end
            end
            PSWC_SLEEP: begin
                if (wake_src) begin
                    next_state = PSWC_WAKE_DELAY;
                end
            end
            PSWC_IDLE: begin
                if (wake_src) begin
                    next_state = PSWC_RUN;
                end
            end
            PSWC_WAKE_DELAY: begin
                if (!delay_busy) begin
                    if (clock_ok || clock_fail_enable) begin
                        next_state = PSWC_RUN;
                    end else begin
                        next_state = PSWC_WAIT_CLOCK;
                    end
                end
            end
            PSWC_WAIT_CLOCK: begin
                if (clock_ok) begin
                    next_state = PSWC_RUN;
                end
            end
            default: next_state = PSWC_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PSWC_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // wake side effects
    // ----------------------------------------------------------------
    logic delay_done;
    assign delay_done = (state == PSWC_WAKE_DELAY) && !delay_busy;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_by_irq           <= 1'b0;
            interrupt_vector_take <= 1'b0;
            clock_fail_trap       <= 1'b0;
            wake_osc              <= 3'h0;
        end else begin
            if (load_delay) begin
                wake_by_irq <= irq_wake;
                wake_osc    <= osc_src;
            end
            interrupt_vector_take <= (next_state == PSWC_RUN)
                && ((state == PSWC_IDLE && irq_wake)
                    || (state != PSWC_IDLE && state != PSWC_RUN && wake_by_irq));
            clock_fail_trap <= delay_done && !clock_ok && clock_fail_enable;
        end
    end

    // ----------------------------------------------------------------
    // reset control register
    // ----------------------------------------------------------------
    logic [15:0] next_rcr;
    logic        in_sleep;
    logic        in_idle;
    logic        wdt_wake;
    assign in_sleep = (state == PSWC_SLEEP);
    assign in_idle  = (state == PSWC_IDLE);
    assign wdt_wake = wdt_active & wdt_overflow & (in_sleep | in_idle);

    always_comb begin
        next_rcr = reset_control_register;
        if (rcr_write) begin
            next_rcr = rcr_wdata;
        end
        // the settled flag drops one cycle after the enable, not two
        next_rcr[`PSWC_RCR_BANDGAP_STABLE_FLAG_BIT] = bandgap_stable_flag & lowvolt_detect_active;
        // hardware sets win over a software write in the same cycle
        if (in_sleep && (irq_wake || wdt_wake || bor_event || master_clear_pin_event)) begin
            next_rcr[`PSWC_RCR_SLEEP_BIT] = 1'b1;
        end
        if (in_idle && (irq_wake || wdt_wake || bor_event || master_clear_pin_event)) begin
            next_rcr[`PSWC_RCR_IDLE_BIT] = 1'b1;
        end
        if (wdt_wake) begin
            next_rcr[`PSWC_RCR_WDT_TIMEOUT_FLAG_BIT] = 1'b1;
        end
        if (por_event) begin
            next_rcr[`PSWC_RCR_SLEEP_BIT] = 1'b0;
            next_rcr[`PSWC_RCR_IDLE_BIT]  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_control_register <= `PSWC_RCR_RESET;
        end else begin
            reset_control_register <= next_rcr;
        end
    end

    // ----------------------------------------------------------------
    // configuration words, read through table reads
    // ----------------------------------------------------------------
    logic [15:0] cfg_sel;
    assign cfg_sel = (cfg_addr == `PSWC_CFG_OSC_ADDR)     ? osc_cfg_word     :
                     (cfg_addr == `PSWC_CFG_WDT_ADDR)     ? wdt_cfg_word     :
                     (cfg_addr == `PSWC_CFG_BORPOR_ADDR)  ? borpor_cfg_word  :
                     (cfg_addr == `PSWC_CFG_BOOT_ADDR)    ? boot_cfg_word    :
                     (cfg_addr == `PSWC_CFG_SECURE_ADDR)  ? secure_cfg_word  :
                     (cfg_addr == `PSWC_CFG_GENERAL_ADDR) ? general_cfg_word :
                     (cfg_addr == `PSWC_CFG_DEBUG_ADDR)   ? debug_cfg_word   : 16'h0000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 24'h000000;
        end else begin
            cfg_rdata <= {8'h00, cfg_sel};
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_sleep_wdt;
        state == PSWC_SLEEP && wdt_active && wdt_overflow;
    endsequence

    chk_fuse_forces_wdt: assert property (@(posedge clk) disable iff (!rst_n)
        wdt_cfg_word[`PSWC_CFG_WDT_FUSE_BIT] |-> wdt_active)
        else $error("fuse set but watchdog inactive");
    chk_soft_enable: assert property (@(posedge clk) disable iff (!rst_n)
        !wdt_cfg_word[`PSWC_CFG_WDT_FUSE_BIT] |->
            wdt_active == reset_control_register[`PSWC_RCR_SOFT_EN_BIT])
        else $error("soft enable not followed");
    chk_no_reset_sleep: assert property (@(posedge clk) disable iff (!rst_n)
        s_sleep_wdt |-> !wdt_reset_request)
        else $error("watchdog reset in sleep");
    chk_wdt_wake_flags: assert property (@(posedge clk) disable iff (!rst_n)
        s_sleep_wdt and !por_event |=> reset_control_register[`PSWC_RCR_WDT_TIMEOUT_FLAG_BIT]
            && reset_control_register[`PSWC_RCR_SLEEP_BIT] && state == PSWC_WAKE_DELAY)
        else $error("watchdog wake flags missing");
    chk_lvd_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !lowvolt_detect_active |=> !reset_control_register[`PSWC_RCR_BANDGAP_STABLE_FLAG_BIT])
        else $error("reference flag without enable");
    chk_sleep_gating: assert property (@(posedge clk) disable iff (!rst_n)
        state == PSWC_SLEEP |-> !cpu_clk_enable && !periph_clk_enable
            && !clock_fail_monitor_active)
        else $error("clocks running in sleep");
    chk_idle_gating: assert property (@(posedge clk) disable iff (!rst_n)
        state == PSWC_IDLE |-> !cpu_clk_enable && periph_clk_enable && osc_enable)
        else $error("idle gating wrong");
    chk_idle_wake: assert property (@(posedge clk) disable iff (!rst_n)
        state == PSWC_IDLE && irq_wake |=> cpu_clk_enable)
        else $error("idle wake delayed");
    chk_por_clears: assert property (@(posedge clk) disable iff (!rst_n)
        por_event |=> !reset_control_register[`PSWC_RCR_SLEEP_BIT]
            && !reset_control_register[`PSWC_RCR_IDLE_BIT])
        else $error("power on did not clear flags");
    chk_rc_delay: assert property (@(posedge clk) disable iff (!rst_n)
        load_delay && !is_crystal |=> ##[1:401] state != PSWC_WAKE_DELAY)
        else $error("rc wake delay too long");
endmodule // pswc_power_save_wake

/* File: pswc_core_model.sv */
// processor core model: issues power save and watchdog clear instructions
`timescale 1ns/10ps
module pswc_core_model (
    input  wire logic clk,
    output logic      power_save_instruction_exec,
    output logic      power_save_instruction_is_idle,
    output logic      wdt_clear_instruction
);
    initial begin
        power_save_instruction_exec = 1'b0;
        power_save_instruction_is_idle = 1'b1;
        wdt_clear_instruction = 1'b0;
    end
    // operand is inverted once the pulse ends, so a stale operand is never trusted
    task automatic power_save(input logic idle);
        @(posedge clk);
        #1;
        power_save_instruction_exec = 1'b1;
        power_save_instruction_is_idle = idle;
        @(posedge clk);
        #1;
        power_save_instruction_exec = 1'b0;
        power_save_instruction_is_idle = ~idle;
    endtask
    task automatic clear_watchdog();
        @(posedge clk);
        #1;
        wdt_clear_instruction = 1'b1;
        @(posedge clk);
        #1;
        wdt_clear_instruction = 1'b0;
    endtask
endmodule // pswc_core_model

/* File: power_save_wake_control_bench.sv */
// self-checking bench for the power save and wake control block
`timescale 1ns/10ps
`include "pswc_consts.svh"
module power_save_wake_control_bench;
    import pswc_pkg::*;
    // short crystal counts keep the run brief
    localparam int LOCK = 1;
    localparam int OSC_STARTUP_TIMER  = 4;
    localparam pswc_osc_t OSC_LIST [8] = '{PSWC_OSC_FRC, PSWC_OSC_LOW_POWER_INTERNAL_RC, PSWC_OSC_EC,
        PSWC_OSC_EXTERNAL_RC_OSC, PSWC_OSC_PRIMARY, PSWC_OSC_XT_PLL, PSWC_OSC_LP, PSWC_OSC_LP};
    logic        clk = 1'b0, rst_n = 1'b0;
    logic        por_event = 1'b0, bor_event = 1'b0, master_clear_pin_event = 1'b0;
    logic        wdt_overflow = 1'b0, irq_wake = 1'b0, clock_switch_enable = 1'b1;
    logic [2:0]  current_osc_select = 3'h0;
    logic        pll_locked = 1'b1, osc_running = 1'b1, lp_ran_in_sleep = 1'b0;
    logic        clock_fail_enable = 1'b0, reference_ready = 1'b0, rcr_write = 1'b0;
    logic [15:0] rcr_wdata = 16'h0000;
    logic [23:0] cfg_addr = 24'h000000;
    logic [15:0] cw [7] = '{16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic        power_save_instruction_exec, power_save_instruction_is_idle, wdt_clear_instruction;
    logic [23:0] cfg_rdata;
    logic [15:0] reset_control_register;
    logic        wdt_active, wdt_counter_clear, wdt_reset_request, cpu_clk_enable;
    logic        periph_clk_enable, osc_enable, low_power_internal_rc_enable, clock_fail_monitor_active;
    logic        lowvolt_detect_active, interrupt_vector_take, clock_fail_trap;
    logic [3:0]  lowvolt_threshold_select;
    logic [2:0]  wake_osc;
    int          n_mismatch = 0, compares = 0, n_vec = 0, n_trap = 0, n_clr = 0;

    pswc_power_save_wake #(.LOCK_CYC(LOCK), .OST_CYC(OSC_STARTUP_TIMER)) pswc_power_save_wake_inst (
        .osc_cfg_word(cw[0]), .wdt_cfg_word(cw[1]), .borpor_cfg_word(cw[2]),
        .boot_cfg_word(cw[3]), .secure_cfg_word(cw[4]), .general_cfg_word(cw[5]),
        .debug_cfg_word(cw[6]), .*);
    pswc_core_model pswc_core_model_inst (.*);

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        if (interrupt_vector_take === 1'b1) n_vec++;
        if (clock_fail_trap === 1'b1) n_trap++;
        if (wdt_counter_clear === 1'b1) n_clr++;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check_val(input logic [23:0] got, input logic [23:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_span(input int got, input int lo, input int hi, input string what);
        compares++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("wrong value at %0t: %s took %0d cycles, %0d..%0d", $time, what, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [15:0] d);
        rcr_wdata = d;
        rcr_write = 1'b1;
        step(1);
        rcr_write = 1'b0;
        rcr_wdata = ~d;
        step(1);
    endtask
    function automatic int wake_cycles(input pswc_osc_t o, input logic lp);
        wake_cycles = `PSWC_POWERON_DELAY_CYC;
        if ((o == PSWC_OSC_PRIMARY || o == PSWC_OSC_XT_PLL || o == PSWC_OSC_LP) &&
            !(o == PSWC_OSC_LP && lp))
            wake_cycles += `PSWC_POWERUP_TIMER_DELAY_CYC + LOCK + OSC_STARTUP_TIMER;
    endfunction
    // src: 0 interrupt, 1 watchdog overflow, 2 master clear, 3 brown-out
    task automatic nap(input logic idle, input pswc_osc_t o, input logic lp, input int src);
        int n;
        int v;
        int e;
        wr(16'h0000);
        // with switching off the select pin is wrong on purpose
        current_osc_select = clock_switch_enable ? o : ~o;
        lp_ran_in_sleep = lp;
        v = n_vec;
        pswc_core_model_inst.power_save(idle);
        check_val(cpu_clk_enable, 1'b0, "cpu clock");
        check_val(periph_clk_enable, idle, "periph clock");
        check_val(osc_enable, idle | lp, "oscillator");
        if (!idle) check_val(clock_fail_monitor_active, 1'b0, "monitor");
        if (!idle) check_val(low_power_internal_rc_enable, 1'b1, "low_power_internal_rc");
        {irq_wake, wdt_overflow, master_clear_pin_event, bor_event} = 4'h8 >> src;
        #1;
        if (src == 1) check_val(wdt_reset_request, !idle ? 1'b0 : 1'b1, "wdt reset");
        step(1);
        {irq_wake, wdt_overflow, master_clear_pin_event, bor_event} = 4'h0;
        n = 0;
        while (cpu_clk_enable !== 1'b1 && n < 3000) begin
            step(1);
            n++;
        end
        check_val(cpu_clk_enable, 1'b1, "awake");
        e = idle ? 1 : wake_cycles(o, lp);
        if (src < 2) check_span(n, e - 1, e + (idle ? 0 : 3), "wake");
        step(3);
        check_val(reset_control_register[`PSWC_RCR_SLEEP_BIT], !idle, "sleep flag");
        check_val(reset_control_register[`PSWC_RCR_IDLE_BIT], idle, "idle flag");
        check_val(reset_control_register[`PSWC_RCR_WDT_TIMEOUT_FLAG_BIT], src == 1, "timeout flag");
        if (!idle) check_val(24'(n_vec - v), src == 0, "vector");
        if (!idle && src < 2) check_val(wake_osc, o, "wake osc");
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        int          i;
        logic [15:0] d;
        void'($urandom(32'h102E847A));
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check_val(reset_control_register, `PSWC_RCR_RESET, "reset value");
        check_val(wdt_active, 1'b1, "erased fuse");
        wdt_overflow = 1'b1;
        #1;
        check_val(wdt_reset_request, 1'b1, "overflow reset");
        step(1);
        wdt_overflow = 1'b0;
        pswc_core_model_inst.clear_watchdog();
        check_val(24'(n_clr), 24'h000001, "wdt clear");
        cw[1] = 16'h7FFF;
        wr(16'h0020);
        check_val(wdt_active, 1'b1, "soft enable");
        wr(16'h0000);
        check_val(wdt_active, 1'b0, "soft disable");
        cw[1] = 16'hFFFF;
        $display("test done: watchdog enable");
        repeat (6) begin
            d = 16'(($urandom & 32'h1F) << 8);
            wr(d);
            check_val(lowvolt_threshold_select, d[11:8], "threshold");
            check_val(lowvolt_detect_active, d[12], "detector");
        end
        wr(16'h1000);
        reference_ready = 1'b1;
        step(`PSWC_BANDGAP_STABLE_FLAG_CYC + 4);
        check_val(reset_control_register[13], 1'b1, "settled");
        wr(16'h1000);
        check_val(reset_control_register[13], 1'b1, "settled kept");
        $display("test done: low voltage");
        for (i = 0; i < 8; i++) begin
            if (i < 7) cw[i] = 16'($urandom);
            if (i == 1) cw[1][15] = 1'b1;
            cfg_addr = 24'hF80000 + 24'(2 * i);
            step(2);
            check_val(cfg_rdata, i < 7 ? {8'h00, cw[i % 7]} : 24'h000000, "config");
        end
        $display("test done: config words");
        for (i = 0; i < 8; i++) nap(1'b0, OSC_LIST[i], i == 7, 0);
        for (i = 1; i < 4; i++) nap(1'b0, PSWC_OSC_FRC, 1'b0, i);
        for (i = 0; i < 4; i++) nap(1'b1, PSWC_OSC_FRC, 1'b0, i);
        repeat (4) nap(1'($urandom), OSC_LIST[$urandom_range(6, 0)], 1'b0, $urandom_range(3, 0));
        clock_switch_enable = 1'b0;
        cw[0] = 16'(PSWC_OSC_PRIMARY);
        nap(1'b0, PSWC_OSC_PRIMARY, 1'b0, 0);
        clock_switch_enable = 1'b1;
        por_event = 1'b1;
        step(1);
        por_event = 1'b0;
        step(2);
        check_val(reset_control_register[3:2], 2'h0, "por clear");
        $display("test done: sleep and idle");
        osc_running = 1'b0;
        clock_fail_enable = 1'b1;
        current_osc_select = PSWC_OSC_FRC;
        lp_ran_in_sleep = 1'b0;
        i = n_trap;
        pswc_core_model_inst.power_save(1'b0);
        irq_wake = 1'b1;
        step(1);
        irq_wake = 1'b0;
        step(wake_cycles(PSWC_OSC_FRC, 1'b0) + 8);
        check_val(24'(n_trap - i), 24'h000001, "clock trap");
        clock_fail_enable = 1'b0;
        pswc_core_model_inst.power_save(1'b0);
        irq_wake = 1'b1;
        step(1);
        irq_wake = 1'b0;
        step(wake_cycles(PSWC_OSC_FRC, 1'b0) + 8);
        check_val(cpu_clk_enable, 1'b0, "stalled");
        osc_running = 1'b1;
        step(2);
        check_val(cpu_clk_enable, 1'b1, "clock back");
        $display("test done: dead clock");
        end_of_test();
    end
    // about 7000 cycles are needed, so 60000 leaves ample room
    initial begin
        #1500000;
        n_mismatch++;
        end_of_test();
    end
endmodule // power_save_wake_control_bench
